// ### dv/desd_enc_model.sv
// quadrature encoder model with index pulse, one per channel
// assumes its tasks are called just after a falling clock edge
`timescale 1ns/1ps
module desd_enc_model (
   input wire logic clk_i,
   output logic a_o,
   output logic b_o,
   output logic z_o
);
   logic [1:0] ph = 2'h0;
   int gap = 8;
   int n_a = 0;
   int n_b = 0;
   int n_z = 0;
   initial begin
      a_o = 1'h0;
      b_o = 1'h0;
      z_o = 1'h0;
   end
   task automatic step(input logic run_forward_cmd);
      ph = run_forward_cmd ? ph + 2'h1 : ph - 2'h1;
      n_a += int'(a_o != ph[1]);
      n_b += int'(b_o != ^ph);
      a_o = ph[1];
      b_o = ^ph;
      repeat (gap) @(negedge clk_i);
   endtask : step
   task automatic index();
      z_o = 1'h1;
      repeat (4) @(negedge clk_i);
      z_o = 1'h0;
      n_z += 2;
      repeat (4) @(negedge clk_i);
   endtask : index
   task automatic home();
      ph = 2'h0;
      a_o = 1'h0;
      b_o = 1'h0;
      n_a = 0;
      n_b = 0;
      n_z = 0;
   endtask : home
endmodule : desd_enc_model

// ### dv/testbench.sv
// self-checking bench for the encoder sync direction block
// assumes two encoder models on the reference and slave channels
`timescale 1ns/1ps
module testbench;
   import desd_pkg::*;
   logic ref_clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic swap = 1'h0;
   logic cmd_f = 1'h0;
   logic cmd_r = 1'h0;
   logic en = 1'h1;
   logic [15:0] lim = 16'hffff;
   logic ra, rb, rz, sa, sb, sz, run_f, run_r, off, alarm, dec;
   desd_pos_t dev;
   logic [95:0] rate;
   logic [31:0] rng = 32'h2ab1;
   logic [31:0] r;
   int n_errors = 0;
   int n_compared = 0;
   int q_sel[$];
   logic [31:0] q_exp[$];
   always #10 ref_clk_i = ~ref_clk_i;
   desd_enc_model enc_ref_i (.clk_i(ref_clk_i), .a_o(ra), .b_o(rb),
      .z_o(rz));
   desd_enc_model enc_slv_i (.clk_i(ref_clk_i), .a_o(sa), .b_o(sb),
      .z_o(sz));
   desd_top desd_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .clk_en_i(en), .ref_phase_a_in_i(swap ? rb : ra),
      .ref_phase_b_in_i(swap ? ra : rb), .ref_index_in_i(rz),
      .slave_phase_a_in_i(sa), .slave_phase_b_in_i(sb),
      .slave_index_in_i(sz), .run_forward_cmd_i(cmd_f),
      .run_backward_cmd_i(cmd_r), .deviation_limit_setting_i(lim),
      .slave_run_fwd_o(run_f), .slave_run_rev_o(run_r),
      .deviation_o(dev), .drive_off_o(off),
      .deviation_alarm_o(alarm), .pulse_rate_o(rate));
   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] seen, input logic [31:0] e);
      n_compared++;
      if (seen !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, e);
      end
   endtask : check
   function automatic logic [31:0] seen_v(input int s);
      case (s)
         0: return {31'h0, run_f};
         1: return {31'h0, run_r};
         2: return dev;
         3: return {31'h0, alarm};
         4: return {31'h0, off};
         default: return {16'h0, rate[16*(s-5) +: 16]};
      endcase
   endfunction : seen_v
   always @(negedge ref_clk_i) begin
      // let the pushing task run first
      #1;
      if (q_sel.size() > 0)
         check(seen_v(q_sel.pop_front()), q_exp.pop_front());
   end
   task automatic want(input int s, input logic [31:0] e);
      q_sel.push_back(s);
      q_exp.push_back(e);
      repeat (2) @(negedge ref_clk_i);
   endtask : want
   task automatic rst_run();
      enc_ref_i.home();
      enc_slv_i.home();
      cmd_f = 1'h0;
      cmd_r = 1'h0;
      rst_i = 1'h1;
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'h0;
      @(negedge ref_clk_i);
   endtask : rst_run
   task automatic steps(input logic rf, input logic run_forward_cmd, input int n);
      repeat (n) begin
         if (rf)
            enc_ref_i.step(run_forward_cmd);
         else
            enc_slv_i.step(run_forward_cmd);
      end
      repeat (10) @(negedge ref_clk_i);
   endtask : steps
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      n_errors++;
      test_done();
   end
   initial begin
      rst_run();
      for (int s = 0; s < 11; s++) want(s, 32'h0);
      en = 1'h0;
      steps(1'h1, 1'h1, 1);
      want(2, 32'h0);
      en = 1'h1;
      repeat (10) @(negedge ref_clk_i);
      want(2, 32'h1);
      $display("reset and enable done");
      for (int k = 0; k < 8; k++) begin
         swap = k[2];
         rst_run();
         cmd_f = k[0];
         cmd_r = !k[0];
         dec = k[1] ^ k[2];
         steps(1'h1, k[1], 2);
         want(0, {31'h0, cmd_f & dec});
         want(1, {31'h0, cmd_r & !dec});
         want(2, dec ? 32'h2 : 32'hffff_fffe);
      end
      $display("direction table done");
      swap = 1'h0;
      rst_run();
      cmd_f = 1'h1;
      cmd_r = 1'h0;
      steps(1'h1, 1'h1, 4);
      want(0, 32'h1);
      steps(1'h1, 1'h0, 6);
      want(0, 32'h0);
      want(2, 32'hffff_fffe);
      steps(1'h1, 1'h1, 1);
      want(0, 32'h0);
      steps(1'h1, 1'h1, 1);
      want(0, 32'h1);
      $display("hold and resume done");
      rst_run();
      steps(1'h1, 1'h1, 8);
      enc_ref_i.index();
      steps(1'h0, 1'h1, 6);
      want(2, 32'h2);
      enc_slv_i.index();
      repeat (10) @(negedge ref_clk_i);
      want(2, 32'h0);
      $display("index correction done");
      rst_run();
      lim = 16'h0001;
      cmd_r = 1'h1;
      enc_ref_i.gap = 4;
      steps(1'h1, 1'h0, 100);
      want(1, 32'h1);
      want(3, 32'h0);
      want(2, 32'hffff_ff9c);
      steps(1'h1, 1'h0, 1);
      want(3, 32'h1);
      want(4, 32'h1);
      want(1, 32'h0);
      $display("alarm boundary done");
      lim = 16'hffff;
      cmd_f = 1'h0;
      rst_run();
      for (int i = 0; i < 40; i++) begin
         rng ^= rng << 13;
         rng ^= rng >> 17;
         rng ^= rng << 5;
         r = rng;
         if (r[1])
            enc_ref_i.step(r[0]);
         else
            enc_slv_i.step(r[0]);
         if (r[4:2] == 3'h0)
            enc_ref_i.index();
         if (r[4:2] == 3'h1)
            enc_slv_i.index();
      end
      for (int i = 0; i < 60000 && rate === 96'h0; i++)
         @(negedge ref_clk_i);
      want(5, enc_ref_i.n_a);
      want(6, enc_ref_i.n_b);
      want(7, enc_ref_i.n_z);
      want(8, enc_slv_i.n_a);
      want(9, enc_slv_i.n_b);
      want(10, enc_slv_i.n_z);
      $display("pulse rate done");
      test_done();
   end
endmodule : testbench

// ### hdl/desd_params.svh
// constants for the dual encoder sync direction block
// assumes inclusion by the package and desd_top
`ifndef DESD_PARAMS_SVH
`define DESD_PARAMS_SVH
`define DESD_POS_W 32
`define DESD_LIM_W 16
`define DESD_RATE_W 16
`define DESD_LIM_MULT 32'sd100
`define DESD_GATE_US 1000
`define DESD_CLK_MHZ 50
`define DESD_GATE_CYC (`DESD_GATE_US * `DESD_CLK_MHZ)
`define DESD_NCH 6
`define DESD_ZERO_POS 32'sh0000_0000
`define DESD_RATE_SAT 16'hffff
`endif

// ### hdl/desd_pkg.sv
// types for the dual encoder sync direction block
// assumes desd_params.svh is on the include path
`include "desd_params.svh"
package desd_pkg;
   typedef enum logic [2:0] {
      DESD_IDLE = 3'b001,
      DESD_RUN = 3'b010,
      DESD_HOLD = 3'b100
   } desd_state_t;
   typedef logic signed [`DESD_POS_W-1:0] desd_pos_t;
   typedef logic [`DESD_RATE_W-1:0] desd_rate_t;
endpackage : desd_pkg

// ### hdl/desd_quad.sv
// one quadrature decoder channel: sync, edge decode, index pulse
// assumes asynchronous a/b/index pins on ref_clk_i
`timescale 1ns/1ps
module desd_quad (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic a_i,
   input wire logic b_i,
   input wire logic z_i,
   output logic step_o,
   output logic dir_fwd_o,
   output logic index_o,
   output logic [2:0] edge_o
);
   logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
   logic step_d, dir_d, idx_d;
   logic step_q, dir_q, idx_q;
   logic [2:0] edge_d, edge_q;
   always_comb begin
      s1_d = {z_i, b_i, a_i};
      s2_d = s1_q;
      s3_d = s2_q;
      edge_d = s2_q ^ s3_q;
      step_d = 1'b0;
      dir_d = dir_q;
      idx_d = s2_q[2] & ~s3_q[2];
      // b leading a by a quarter cycle is forward
      case ({s3_q[0], s3_q[1], s2_q[0], s2_q[1]}) // RULE_01 RULE_11
         4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            step_d = 1'b1;
            dir_d = 1'b0;
         end
         4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            step_d = 1'b1;
            dir_d = 1'b1;
         end
         default: begin
            step_d = 1'b0;
         end
      endcase
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         step_q <= 1'b0;
         dir_q <= 1'b1;
         idx_q <= 1'b0;
         edge_q <= 3'h0;
      end else if (en_i) begin
         s1_q <= s1_d; // RULE_11
         s2_q <= s2_d;
         s3_q <= s3_d;
         step_q <= step_d;
         dir_q <= dir_d;
         idx_q <= idx_d;
         edge_q <= edge_d;
      end
   end
   assign step_o = step_q;
   assign dir_fwd_o = dir_q;
   assign index_o = idx_q;
   assign edge_o = edge_q;
endmodule : desd_quad

// ### hdl/desd_top.sv
// synchronous drive encoder input: direction gate, deviation, alarm
// assumes encoder pins asynchronous, commands on ref_clk_i
// Contract
// (RULE_01) b leading a decodes as forward
// (RULE_02) channel one reference, channel two slave
// (RULE_03) slave follows only matching direction command
// (RULE_04) swapped reference inverts decoded direction
// (RULE_05) hold keeps accumulating reference into deviation
// (RULE_06) resume when deviation returns to zero
// (RULE_07) swap reference a/b for opposite run
// (RULE_08) pulse rate measured on six inputs
// (RULE_09) trip when deviation exceeds hundred times limit
// (RULE_10) index difference corrects a/b miscount
// (RULE_11) two flop sync, each edge counted once
`timescale 1ns/1ps
`include "desd_params.svh"
module desd_top
   import desd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic ref_phase_a_in_i,
   input wire logic ref_phase_b_in_i,
   input wire logic ref_index_in_i,
   input wire logic slave_phase_a_in_i,
   input wire logic slave_phase_b_in_i,
   input wire logic slave_index_in_i,
   input wire logic run_forward_cmd_i,
   input wire logic run_backward_cmd_i,
   input wire logic [`DESD_LIM_W-1:0] deviation_limit_setting_i,
   output logic slave_run_fwd_o,
   output logic slave_run_rev_o,
   output desd_pkg::desd_pos_t deviation_o,
   output logic drive_off_o,
   output logic deviation_alarm_o,
   output logic [`DESD_NCH*`DESD_RATE_W-1:0] pulse_rate_o
);
   import desd_pkg::*;
   logic r_step, r_fwd, r_idx, s_step, s_fwd, s_idx;
   logic [2:0] r_edge, s_edge;
   logic [`DESD_NCH-1:0] edges;
   // channel one reference, channel two slave
   desd_quad u_ref ( // RULE_02
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .a_i(ref_phase_a_in_i), .b_i(ref_phase_b_in_i),
      .z_i(ref_index_in_i), .step_o(r_step), .dir_fwd_o(r_fwd),
      .index_o(r_idx), .edge_o(r_edge)
   );
   desd_quad u_slv ( // RULE_02
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .en_i(clk_en_i),
      .a_i(slave_phase_a_in_i), .b_i(slave_phase_b_in_i),
      .z_i(slave_index_in_i), .step_o(s_step), .dir_fwd_o(s_fwd),
      .index_o(s_idx), .edge_o(s_edge)
   );
   assign edges = {s_edge, r_edge};

   // deviation and direction gate
   desd_state_t st_q, st_d;
   desd_pos_t dev_q, dev_d, zpos_q, zpos_d, rpos_q, rpos_d;
   desd_pos_t spos_q, spos_d, lim_x100;
   logic fwd_q, fwd_d, rev_q, rev_d, alm_q, alm_d;
   logic match, cmd_on, rz_seen_q, rz_seen_d;
   logic signed [`DESD_POS_W-1:0] absdev;
   always_comb begin
      lim_x100 = desd_pos_t'(`DESD_LIM_MULT
         * $signed({1'b0, deviation_limit_setting_i}));
      cmd_on = run_forward_cmd_i ^ run_backward_cmd_i;
      // swapped wiring already flips r_fwd at decode
      match = (r_fwd & run_forward_cmd_i & ~run_backward_cmd_i)
         | (~r_fwd & run_backward_cmd_i & ~run_forward_cmd_i); // RULE_03 RULE_04
      rpos_d = rpos_q;
      spos_d = spos_q;
      zpos_d = zpos_q;
      rz_seen_d = rz_seen_q;
      if (r_step) begin
         rpos_d = r_fwd ? rpos_q + 1 : rpos_q - 1; // RULE_05
      end
      if (s_step) begin
         spos_d = s_fwd ? spos_q + 1 : spos_q - 1;
      end
      // index pair realigns slave count to reference latch
      if (s_idx && rz_seen_q) begin // RULE_10
         spos_d = zpos_q;
         rz_seen_d = 1'b0;
      end
      // a fresh reference index wins over the clear
      if (r_idx) begin
         zpos_d = rpos_d;
         rz_seen_d = 1'b1;
      end
      dev_d = rpos_d - spos_d;
      absdev = dev_d[`DESD_POS_W-1] ? -dev_d : dev_d;
      alm_d = alm_q | (absdev > lim_x100); // RULE_09
      st_d = st_q;
      fwd_d = 1'b0;
      rev_d = 1'b0;
      case (st_q)
         DESD_IDLE: begin
            // hold only once the reference really turns the wrong way
            if (cmd_on && !alm_q) begin
               if (match) begin
                  st_d = DESD_RUN; // RULE_03
               end else if (r_step) begin
                  st_d = DESD_HOLD; // RULE_05
               end
            end
         end
         DESD_RUN: begin
            fwd_d = run_forward_cmd_i;
            rev_d = run_backward_cmd_i;
            if (!cmd_on || alm_q) begin
               st_d = DESD_IDLE;
            end else if (!match) begin
               st_d = DESD_HOLD; // RULE_03
            end
         end
         DESD_HOLD: begin
            if (!cmd_on || alm_q) begin
               st_d = DESD_IDLE;
            end else if (match && dev_d == `DESD_ZERO_POS) begin
               st_d = DESD_RUN; // RULE_06
            end
         end
         default: begin
            st_d = DESD_IDLE;
         end
      endcase
      if (alm_d) begin
         fwd_d = 1'b0;
         rev_d = 1'b0;
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= DESD_IDLE;
         rpos_q <= `DESD_ZERO_POS;
         spos_q <= `DESD_ZERO_POS;
         zpos_q <= `DESD_ZERO_POS;
         dev_q <= `DESD_ZERO_POS;
         rz_seen_q <= 1'b0;
         fwd_q <= 1'b0;
         rev_q <= 1'b0;
         alm_q <= 1'b0;
      end else if (clk_en_i) begin
         st_q <= st_d;
         rpos_q <= rpos_d;
         spos_q <= spos_d;
         zpos_q <= zpos_d;
         dev_q <= dev_d;
         rz_seen_q <= rz_seen_d;
         fwd_q <= fwd_d;
         rev_q <= rev_d;
         alm_q <= alm_d;
      end
   end
   assign slave_run_fwd_o = fwd_q;
   assign slave_run_rev_o = rev_q;
   assign deviation_o = dev_q;
   assign drive_off_o = alm_q;
   assign deviation_alarm_o = alm_q;

   // pulse rate per input: edges per gate window
   logic [31:0] gate_q, gate_d;
   logic gate_end;
   always_comb begin
      gate_end = (gate_q == 32'(`DESD_GATE_CYC - 1));
      gate_d = gate_end ? 32'h0 : gate_q + 32'h1;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gate_q <= 32'h0;
      end else if (clk_en_i) begin
         gate_q <= gate_d;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < `DESD_NCH; gi++) begin : g_rate
         desd_rate_t cnt_q, cnt_d, rate_q, rate_d;
         always_comb begin
            cnt_d = cnt_q;
            if (edges[gi] && cnt_q != `DESD_RATE_SAT) begin
               cnt_d = cnt_q + 1'b1;
            end
            rate_d = rate_q;
            if (gate_end) begin
               rate_d = cnt_d; // RULE_08
               cnt_d = '0;
            end
         end
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               cnt_q <= '0;
               rate_q <= '0;
            end else if (clk_en_i) begin
               cnt_q <= cnt_d;
               rate_q <= rate_d;
            end
         end
         assign pulse_rate_o[gi*`DESD_RATE_W +: `DESD_RATE_W] = rate_q;
      end
   endgenerate

   property p_alarm_stops;
      @(posedge ref_clk_i) disable iff (rst_i)
      alm_q |-> !slave_run_fwd_o && !slave_run_rev_o;
   endproperty
   a_alarm_stops: assert property (p_alarm_stops) // RULE_09
      else $error("motion while alarm");
   property p_hold_still;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && st_q == DESD_HOLD) |=> !fwd_q && !rev_q;
   endproperty
   a_hold_still: assert property (p_hold_still) // RULE_03
      else $error("slave moved in hold");
   property p_alarm_sticky;
      @(posedge ref_clk_i) disable iff (rst_i)
      alm_q |=> alm_q;
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky) // RULE_09
      else $error("alarm dropped");
   property p_ref_counts;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && r_step && !s_step && !s_idx && r_fwd) |=>
         rpos_q == $past(rpos_q) + 1;
   endproperty
   a_ref_counts: assert property (p_ref_counts) // RULE_05
      else $error("reference step lost");
   sequence s_hold_then_run;
      (st_q == DESD_HOLD) ##1 (st_q == DESD_RUN);
   endsequence
   property p_resume_zero;
      @(posedge ref_clk_i) disable iff (rst_i)
      s_hold_then_run |-> dev_q == `DESD_ZERO_POS;
   endproperty
   a_resume_zero: assert property (p_resume_zero) // RULE_06
      else $error("resumed off zero");
   property p_mismatch_stop;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && st_q == DESD_RUN && !match) |=> st_q != DESD_RUN;
   endproperty
   a_mismatch_stop: assert property (p_mismatch_stop) // RULE_03
      else $error("run kept on mismatch");
   property p_index_fix;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && s_idx && rz_seen_q) |=> spos_q == $past(zpos_q);
   endproperty
   a_index_fix: assert property (p_index_fix) // RULE_10
      else $error("index correction missed");
   property p_dev_track;
      @(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i |=> dev_q == rpos_q - spos_q;
   endproperty
   a_dev_track: assert property (p_dev_track) // RULE_05
      else $error("deviation mismatch");
endmodule : desd_top
